// File: logic/adcsc_pkg.sv
`default_nettype none
package adcsc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_START = 8'hb4;
    localparam logic [7:0] IDX_SEQ = 8'hb5;
    localparam logic [7:0] IDX_EXTRA = 8'hb6;
    localparam logic [7:0] IDX_RES_LO = 8'hba;
    localparam logic [7:0] IDX_RES_HI = 8'hbb;
    localparam logic [7:0] IDX_PIN_EN = 8'hf2;
    // adc_start_control fields
    localparam int BIT_EOC = 7;
    localparam int BIT_ST = 6;
    localparam int POS_START_SOURCE_SELECT = 4;
    localparam int POS_RANDOM_GEN_CONTROL = 2;
    localparam logic [1:0] START_RSVD = 2'h3;
    // reset values
    localparam logic [1:0] RST_START_SOURCE_SELECT = 2'h3;
    localparam logic [1:0] RST_RANDOM_GEN_CONTROL = 2'h0;
    localparam logic [7:0] RST_SEQ_CFG = 8'h10;
    localparam logic [7:0] RST_EXTRA_CFG = 8'h00;
    localparam logic [7:0] RST_PIN_EN = 8'h00;
    localparam logic [13:0] RST_RESULT = 14'h0000;
    // start sources
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_FREE = 2'h1;
    localparam logic [1:0] SRC_TIMER = 2'h2;
    localparam logic [1:0] SRC_SOFT = 2'h3;
    // random generator control
    localparam logic [1:0] RNG_NORMAL = 2'h0;
    localparam logic [1:0] RNG_ONCE = 2'h1;
    localparam logic [1:0] RNG_STOP = 2'h3;
    // channel map
    localparam logic [3:0] CH_FIRST_DIFF = 4'h8;
    localparam logic [3:0] CH_LAST_SEQ = 4'hc;
    // timing: converter clock divider and settling, in converter ticks
    localparam int CONV_CLK_DIV = 8;
    localparam logic [2:0] DIV_LAST = 3'(CONV_CLK_DIV - 1);
    localparam logic [9:0] SETTLE_TICKS = 10'h010;
    localparam logic [9:0] DEC_64 = 10'h040;
    localparam logic [9:0] DEC_128 = 10'h080;
    localparam logic [9:0] DEC_256 = 10'h100;
    localparam logic [9:0] DEC_512 = 10'h200;
    // result saturation limits (14-bit left aligned)
    localparam logic signed [15:0] RES_MAX = 16'sh1fff;
    localparam logic signed [15:0] RES_MIN = -16'sh2000;

    typedef struct packed {
        logic [1:0] ref_sel;
        logic [1:0] dec_sel;
        logic [3:0] chan;
    } adcsc_cfg_t;

    typedef struct packed {
        logic [7:0] chan;
        logic any;
    } adcsc_dma_t;
endpackage
`default_nettype wire

// File: logic/adcsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module adcsc_top
    import adcsc_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // analog front end
    output logic ADC_CLK_EN,
    output adcsc_cfg_t AFE_CMD,
    output logic AFE_BUSY,
    output logic AFE_SETTLE,
    input wire logic [15:0] FILTER_DATA,
    // start events
    input wire logic EXT_TRIG_PIN,
    input wire logic T1_CMP_EVENT,
    // dma and interrupt
    output adcsc_dma_t DMA_TRIG,
    output logic IRQ,
    // random generator
    output logic [1:0] RNG_CTRL,
    output logic RNG_STEP
);
    typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_FILTER} adcsc_state_t;

    // channel usable given pin analog enables
    function automatic logic chan_ok(input logic [3:0] ch, input logic [7:0] en);
        logic ok;
        ok = 1'b1;
        if (ch < CH_FIRST_DIFF) begin
            ok = en[ch[2:0]];
        end else if (ch < CH_LAST_SEQ) begin
            ok = en[{ch[1:0], 1'b0}] & en[{ch[1:0], 1'b1}];
        end
        return ok;
    endfunction

    // first usable channel in [from, last]; msb flags found
    function automatic logic [4:0] next_chan(input logic [4:0] from, input logic [3:0] last,
                                             input logic [7:0] en);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (5'(i) >= from && 4'(i) <= last && chan_ok(4'(i), en)) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [9:0] dec_ticks(input logic [1:0] d);
        logic [9:0] t;
        case (d)
            2'h0: t = DEC_64;
            2'h1: t = DEC_128;
            2'h2: t = DEC_256;
            default: t = DEC_512;
        endcase
        return t;
    endfunction

    // clamp to 14 bits; single-ended never goes negative
    function automatic logic [13:0] fmt_result(input logic [15:0] raw, input logic se);
        logic [13:0] r;
        if (se && raw[15]) begin
            r = 14'h0000;
        end else if ($signed(raw) > RES_MAX) begin
            r = RES_MAX[13:0];
        end else if ($signed(raw) < RES_MIN) begin
            r = RES_MIN[13:0];
        end else begin
            r = raw[13:0];
        end
        return r;
    endfunction

    logic ack_q;
    logic [7:0] dat_q;
    logic eoc_q;
    logic st_q;
    logic [1:0] start_source_select_q;
    logic [1:0] random_gen_control_q;
    logic rng_step_q;
    adcsc_cfg_t seq_cfg_q;
    adcsc_cfg_t extra_cfg_q;
    logic [7:0] pin_en_q;
    logic [3:0] rb_ch_q;
    logic [13:0] res_q;
    logic extra_pend_q;
    logic seq_run_q;
    logic [3:0] seq_ch_q;
    adcsc_state_t state_q;
    adcsc_cfg_t cmd_q;
    logic cur_extra_q;
    logic [9:0] cnt_q;
    logic [2:0] div_q;
    logic ext_q;
    adcsc_dma_t dma_q;
    logic irq_q;

    // bus decode
    wire [7:0] idx = WB_ADR_I[9:2];
    wire req = WB_CYC_I & WB_STB_I;
    wire rd_req = req & ~ack_q & ~WB_WE_I;
    wire wr_req = req & ack_q & WB_WE_I & WB_SEL_I[0];
    wire wr_start = wr_req & (idx == IDX_START);
    wire wr_seq = wr_req & (idx == IDX_SEQ);
    wire wr_extra = wr_req & (idx == IDX_EXTRA);
    wire wr_pin = wr_req & (idx == IDX_PIN_EN);
    wire rd_hi = rd_req & (idx == IDX_RES_HI);
    wire [7:0] start_rd = {eoc_q, st_q, start_source_select_q, random_gen_control_q, START_RSVD};
    // channel field reads back result channel plus one
    wire [7:0] seq_rd = {seq_cfg_q.ref_sel, seq_cfg_q.dec_sel, rb_ch_q};
    // left aligned: 13:6 high, 5:0 in low 7:2
    wire [7:0] lo_rd = {res_q[5:0], 2'h0};
    wire [7:0] hi_rd = res_q[13:6];
    wire [7:0] rd_mux = (idx == IDX_START) ? start_rd :
                        (idx == IDX_SEQ) ? seq_rd :
                        (idx == IDX_EXTRA) ? extra_cfg_q :
                        (idx == IDX_RES_LO) ? lo_rd :
                        (idx == IDX_RES_HI) ? hi_rd :
                        (idx == IDX_PIN_EN) ? pin_en_q : 8'h00;

    // converter tick
    wire tick = (div_q == DIV_LAST);
    wire idle = (state_q == S_IDLE);
    wire conv_done = (state_q == S_FILTER) & tick & (cnt_q == 10'h000);
    wire done_seq = conv_done & ~cur_extra_q;
    wire done_extra = conv_done & cur_extra_q;

    // first channel of a sequence from the last-channel field
    wire [3:0] last = seq_cfg_q.chan;
    wire [3:0] first_from = (last < CH_FIRST_DIFF) ? 4'h0 :
                            (last <= CH_LAST_SEQ) ? CH_FIRST_DIFF : last;
    wire [4:0] first = next_chan({1'b0, first_from}, last, pin_en_q);
    wire [4:0] nxt = next_chan({1'b0, cmd_q.chan} + 5'h01, last, pin_en_q);

    wire ext_rise = EXT_TRIG_PIN & ~ext_q;
    wire [1:0] start_source_select_new = WB_DAT_I[POS_START_SOURCE_SELECT +: 2];
    // start bit honoured only with software source
    wire soft_go = wr_start & WB_DAT_I[BIT_ST] & (start_source_select_new == SRC_SOFT);
    wire event_go = (start_source_select_q == SRC_PIN) ? ext_rise :
                    (start_source_select_q == SRC_FREE) ? 1'b1 :
                    (start_source_select_q == SRC_TIMER) ? T1_CMP_EVENT : soft_go;
    wire seq_go = ~seq_run_q & event_go;
    wire seq_start = seq_go & first[4];
    wire seq_last_done = done_seq & ~nxt[4];
    wire seq_end = (seq_go & ~first[4]) | seq_last_done;

    // extra conversion has priority once the converter is free
    wire start_extra = idle & extra_pend_q;
    wire start_seq = idle & ~extra_pend_q & seq_run_q;
    wire conv_start = start_extra | start_seq;
    wire single_ended = (cmd_q.chan < CH_FIRST_DIFF) | (cmd_q.chan >= CH_LAST_SEQ);

    // wishbone slave: ack one cycle after request, data registered
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ack_q <= 1'b0;
            dat_q <= 8'h00;
        end else begin
            ack_q <= req & ~ack_q;
            if (rd_req) begin
                dat_q <= rd_mux;
            end
        end
    end

    // software-written registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            start_source_select_q <= RST_START_SOURCE_SELECT;
            seq_cfg_q <= RST_SEQ_CFG;
            extra_cfg_q <= RST_EXTRA_CFG;
            pin_en_q <= RST_PIN_EN;
        end else begin
            if (wr_start) begin
                start_source_select_q <= start_source_select_new;
            end
            if (wr_seq) begin
                seq_cfg_q <= WB_DAT_I[7:0];
            end
            // same field layout as sequence config
            if (wr_extra) begin
                extra_cfg_q <= WB_DAT_I[7:0];
            end
            if (wr_pin) begin
                pin_en_q <= WB_DAT_I[7:0];
            end
        end
    end

    // random control; step setting falls back to normal
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            random_gen_control_q <= RST_RANDOM_GEN_CONTROL;
            rng_step_q <= 1'b0;
        end else begin
            rng_step_q <= (random_gen_control_q == RNG_ONCE);
            if (wr_start) begin
                random_gen_control_q <= WB_DAT_I[POS_RANDOM_GEN_CONTROL +: 2];
            end else if (random_gen_control_q == RNG_ONCE) begin
                random_gen_control_q <= RNG_NORMAL;
            end
        end
    end

    // sequence bookkeeping
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_q <= 1'b0;
            seq_run_q <= 1'b0;
            seq_ch_q <= 4'h0;
            extra_pend_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            ext_q <= EXT_TRIG_PIN;
            // start bit holds until sequence completes
            if (seq_end) begin
                st_q <= 1'b0;
            end else if (soft_go & ~seq_run_q) begin
                st_q <= 1'b1;
            end
            if (seq_start) begin
                seq_run_q <= 1'b1;
                seq_ch_q <= first[3:0];
            end else if (seq_last_done) begin
                seq_run_q <= 1'b0;
            end else if (done_seq) begin
                seq_ch_q <= nxt[3:0];
            end
            // write queues an extra conversion; new write wins over start
            if (wr_extra) begin
                extra_pend_q <= 1'b1;
            end else if (start_extra) begin
                extra_pend_q <= 1'b0;
            end
        end
    end

    // conversion timing
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q <= S_IDLE;
            cmd_q <= RST_EXTRA_CFG;
            cur_extra_q <= 1'b0;
            cnt_q <= 10'h000;
            div_q <= 3'h0;
        end else begin
            // divide by eight, realigned at each start
            div_q <= (conv_start | tick) ? 3'h0 : div_q + 3'h1;
            case (state_q)
                S_IDLE: begin
                    if (conv_start) begin
                        cmd_q <= start_extra ? extra_cfg_q :
                                 {seq_cfg_q.ref_sel, seq_cfg_q.dec_sel, seq_ch_q};
                        cur_extra_q <= start_extra;
                        cnt_q <= SETTLE_TICKS - 10'h001;
                        state_q <= S_SETTLE;
                    end
                end
                // 16 settling ticks then rate ticks
                S_SETTLE: begin
                    if (tick) begin
                        if (cnt_q == 10'h000) begin
                            cnt_q <= dec_ticks(cmd_q.dec_sel) - 10'h001;
                            state_q <= S_FILTER;
                        end else begin
                            cnt_q <= cnt_q - 10'h001;
                        end
                    end
                end
                S_FILTER: begin
                    if (tick) begin
                        if (cnt_q == 10'h000) begin
                            state_q <= S_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 10'h001;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // results and end flag
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            res_q <= RST_RESULT;
            rb_ch_q <= 4'h0;
            eoc_q <= 1'b0;
        end else begin
            // result, readback and flag in one cycle
            if (conv_done) begin
                // saturate so 14-bit full scale is 8191 / -8192
                res_q <= fmt_result(FILTER_DATA, single_ended);
                rb_ch_q <= cmd_q.chan + 4'h1;
            end
            // set wins over clear by high read
            eoc_q <= conv_done | (eoc_q & ~rd_hi);
        end
    end

    // event pulses
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            dma_q <= '0;
            irq_q <= 1'b0;
        end else begin
            // one-cycle DMA pulses on sequence done
            dma_q.any <= done_seq;
            dma_q.chan <= (done_seq && cmd_q.chan < CH_FIRST_DIFF) ?
                          8'(8'h01 << cmd_q.chan[2:0]) : 8'h00;
            irq_q <= done_extra;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = {24'h000000, dat_q};
    assign ADC_CLK_EN = tick;
    // reference code passes to the front end unchanged
    assign AFE_CMD = cmd_q;
    assign AFE_BUSY = ~idle;
    assign AFE_SETTLE = (state_q == S_SETTLE);
    assign DMA_TRIG = dma_q;
    assign IRQ = irq_q;
    assign RNG_CTRL = random_gen_control_q;
    assign RNG_STEP = rng_step_q;
endmodule // adcsc_top
`default_nettype wire

// File: testbench/adcsc_filter_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcsc_filter_model
    import adcsc_pkg::*;
#(
    parameter logic [15:0] SAMPLE = 16'h0abc
)
(
    // clock
    input wire logic clock,
    // converter state
    input wire logic afe_busy,
    input wire adcsc_cfg_t afe_cmd,
    // filter result
    output logic [15:0] filter_data
);
    logic [15:0] junk_q = 16'h5a5a;

    always_ff @(posedge clock) begin
        junk_q <= ~junk_q + 16'h0001;
    end

    // idle output is garbage, never a stale sample
    // differential pairs give the negated sample so signed results get exercised
    assign filter_data = !afe_busy ? junk_q :
                         (afe_cmd.chan[3:2] == 2'b10) ? 16'h0000 - SAMPLE : SAMPLE;
endmodule // adcsc_filter_model
`default_nettype wire

// File: testbench/adcsc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module adcsc_monitor
    import adcsc_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // bus
    input wire logic WB_ACK_O,
    // converter
    input wire logic ADC_CLK_EN,
    input wire adcsc_cfg_t AFE_CMD,
    input wire logic AFE_BUSY,
    input wire logic AFE_SETTLE,
    // events
    input wire adcsc_dma_t DMA_TRIG,
    input wire logic IRQ,
    input wire logic [1:0] RNG_CTRL,
    input wire logic RNG_STEP
);
    logic [7:0] settle_q;
    logic [12:0] busy_q;
    wire logic [12:0] conv_len;

    assign conv_len = 13'((16 + (64 << AFE_CMD.dec_sel)) * 8);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            settle_q <= 8'h00;
            busy_q <= 13'h0000;
        end else begin
            settle_q <= AFE_SETTLE ? settle_q + 8'h01 : 8'h00;
            busy_q <= AFE_BUSY ? busy_q + 13'h0001 : 13'h0000;
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    chk_irq_pulse: assert property (IRQ |=> !IRQ)
        else $error("irq longer than one cycle");
    chk_any_pulse: assert property (DMA_TRIG.any |=> !DMA_TRIG.any)
        else $error("dma trigger longer than one cycle");
    chk_irq_no_dma: assert property (IRQ |-> !DMA_TRIG.any && DMA_TRIG.chan == 8'h00)
        else $error("irq together with dma trigger");
    chk_event_after_done: assert property ((IRQ || DMA_TRIG.any)
        |-> !AFE_BUSY && $past(AFE_BUSY))
        else $error("event not one cycle after completion");
    chk_chan_any: assert property (DMA_TRIG.chan != 8'h00
        |-> DMA_TRIG.any && $onehot(DMA_TRIG.chan))
        else $error("per-channel trigger without any trigger");
    chk_settle_start: assert property ($rose(AFE_BUSY) |-> AFE_SETTLE)
        else $error("conversion starts without settling");
    chk_settle_len: assert property ((!AFE_SETTLE && settle_q != 8'h00)
        |-> settle_q == 8'h80)
        else $error("settling length wrong");
    chk_conv_len: assert property ((!AFE_BUSY && busy_q != 13'h0000)
        |-> busy_q == conv_len)
        else $error("conversion length wrong");
    chk_clk_div: assert property ((ADC_CLK_EN && AFE_BUSY) |=> (!ADC_CLK_EN) [*7])
        else $error("converter tick not every eight clocks");
    chk_rng_step: assert property (RNG_STEP |-> $past(RNG_CTRL) == RNG_ONCE)
        else $error("random step without step request");
    chk_rng_return: assert property (RNG_CTRL == RNG_ONCE
        |-> ##[1:2] RNG_CTRL == RNG_NORMAL)
        else $error("random control did not return to normal");
    chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");

    cover property (IRQ);
    cover property (DMA_TRIG.any);
    cover property (RNG_STEP);
endmodule // adcsc_monitor

bind adcsc_top adcsc_monitor u_adcsc_monitor (.CLOCK(CLOCK), .RST(RST),
    .WB_ACK_O(WB_ACK_O), .ADC_CLK_EN(ADC_CLK_EN), .AFE_CMD(AFE_CMD),
    .AFE_BUSY(AFE_BUSY), .AFE_SETTLE(AFE_SETTLE), .DMA_TRIG(DMA_TRIG),
    .IRQ(IRQ), .RNG_CTRL(RNG_CTRL), .RNG_STEP(RNG_STEP));
`default_nettype wire

// File: testbench/adcsc_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module adcsc_top_test;
    import adcsc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h00000000;
    logic ext_pin = 1'b0;
    logic t1_evt = 1'b0;
    logic [31:0] rdat;
    logic ack, clk_en, busy, settle, irq, rng_step;
    logic [1:0] rng_ctrl;
    adcsc_cfg_t afe_cmd;
    adcsc_dma_t dma;
    wire logic [15:0] filter_data;
    int fail_count = 0;
    int comparisons = 0;
    int any_cnt = 0;
    int n;
    logic [7:0] chan_seen = 8'h00;
    logic rng_seen = 1'b0;
    logic [7:0] rd;
    logic [7:0] idx_tab [7] = '{IDX_START, IDX_SEQ, IDX_EXTRA, IDX_RES_LO,
        IDX_RES_HI, IDX_PIN_EN, 8'h10};
    logic [7:0] exp_tab [7] = '{8'h33, RST_SEQ_CFG, RST_EXTRA_CFG, 8'h00,
        8'h00, RST_PIN_EN, 8'h00};
    logic [1:0] src_tab [2] = '{SRC_PIN, SRC_TIMER};

    always #50 clock = ~clock;

    adcsc_top u_adcsc_top (.CLOCK(clock), .RST(rst), .WB_CYC_I(req), .WB_STB_I(req),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .ADC_CLK_EN(clk_en), .AFE_CMD(afe_cmd),
        .AFE_BUSY(busy), .AFE_SETTLE(settle), .FILTER_DATA(filter_data),
        .EXT_TRIG_PIN(ext_pin), .T1_CMP_EVENT(t1_evt), .DMA_TRIG(dma),
        .IRQ(irq), .RNG_CTRL(rng_ctrl), .RNG_STEP(rng_step));

    adcsc_filter_model u_adcsc_filter_model (.clock(clock), .afe_busy(busy),
        .afe_cmd(afe_cmd), .filter_data(filter_data));

    always @(posedge clock) begin
        if (dma.any === 1'b1) any_cnt++;
        // outputs are unknown before the first reset edge
        if (rst === 1'b0) chan_seen = chan_seen | dma.chan;
        if (rng_step === 1'b1) rng_seen = 1'b1;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        req <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        // no cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        req <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check8(rd, exp);
    endtask

    task automatic print_verdict;
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        tick(20000);
        fail_count++;
        print_verdict;
    end

    initial begin
        tick(3);
        rst <= 1'b0;
        tick(1);
        foreach (idx_tab[i]) rd_chk(idx_tab[i], exp_tab[i]);
        // extra conversion of ground
        wb(1'b1, IDX_EXTRA, 8'h0c);
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
        check8(irq, 8'h01);
        check8(8'(any_cnt), 8'h00);
        tick(2);
        rd_chk(IDX_START, 8'hb3);
        rd_chk(IDX_SEQ, 8'h1d);
        rd_chk(IDX_RES_HI, 8'h2a);
        rd_chk(IDX_RES_LO, 8'hf0);
        rd_chk(IDX_START, 8'h33);
        // inputs 0 and 2 enabled, sequence up to 2
        wb(1'b1, IDX_PIN_EN, 8'h05);
        wb(1'b1, IDX_SEQ, 8'h02);
        wb(1'b1, IDX_START, 8'h73);
        n = 0;
        do begin
            wb(1'b0, IDX_START, 8'h00);
            if (n == 0) check8(rd & 8'h40, 8'h40);
            n++;
        end while (rd[BIT_ST] === 1'b1 && n < 2000);
        check8(rd & 8'h40, 8'h00);
        tick(2);
        check8(chan_seen, 8'h05);
        check8(8'(any_cnt), 8'h02);
        rd_chk(IDX_SEQ, 8'h03);
        // differential pairs 8..9, start by pin then timer
        wb(1'b1, IDX_PIN_EN, 8'h0f);
        wb(1'b1, IDX_SEQ, 8'h09);
        foreach (src_tab[i]) begin
            any_cnt = 0;
            wb(1'b1, IDX_START, {2'b01, src_tab[i], 4'h3});
            tick(20);
            check8(busy, 8'h00);
            if (src_tab[i] == SRC_PIN) ext_pin <= 1'b1;
            else t1_evt <= 1'b1;
            tick(1);
            ext_pin <= 1'b0;
            t1_evt <= 1'b0;
            tick(1500);
            check8(8'(any_cnt), 8'h02);
        end
        // random generator step and stop
        // last result is pair 9, negated sample from the model
        rd_chk(IDX_RES_HI, 8'hd5);
        rd_chk(IDX_RES_LO, 8'h10);
        rd_chk(IDX_SEQ, 8'h0a);
        wb(1'b1, IDX_START, 8'h37);
        tick(3);
        check8(rng_seen, 8'h01);
        rd_chk(IDX_START, 8'h33);
        wb(1'b1, IDX_START, 8'h3f);
        check8(rng_ctrl, RNG_STOP);
        print_verdict;
    end
endmodule // adcsc_top_test
`default_nettype wire
